//--- rtl/tsp_consts.vh
`ifndef TSP_CONSTS_VH
`define TSP_CONSTS_VH
`define TSP_ADDR_COUNT 8'h01
`define TSP_ADDR_INTCTL 8'h0B
`define TSP_ADDR_OPTION 8'h81
`define TSP_OPTION_RESET 8'hFF
`define TSP_INTCTL_RESET 8'h00
`define TSP_COUNT_RESET 8'h00
`define TSP_BIT_IRQ_EN 5
`define TSP_BIT_OVF_FLAG 2
`define TSP_BIT_SRC 5
`define TSP_BIT_EDGE 4
`define TSP_BIT_ASSIGN 3
`define TSP_PHASES 4
`define TSP_INHIBIT_CYCLES 2'h2
`endif

//--- rtl/tsp_prescaler.v
`timescale 1ns/1ns
`include "tsp_consts.vh"
module tsp_prescaler (
  // clock and reset
  input wire clk,
  input wire rstn,
  // control
  input wire clear,
  input wire tick,
  input wire [2:0] ratio,
  input wire half_off,
  // output
  output reg out_r
);
  reg [7:0] cnt_r;
  wire [7:0] cnt_nxt;
  wire [7:0] taps;
  genvar i;

  assign cnt_nxt = cnt_r + 8'h01;
  // tap per bit: bit i toggles every 2^i ticks
  generate
    for (i = 0; i < 8; i = i + 1)
    begin : g_tap
      assign taps[i] = cnt_r[i];
    end
  endgenerate

  // count is internal only, never on the register port
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cnt_r <= 8'h00;
      out_r <= 1'b0;
    end
    else if (clear)
    begin
      cnt_r <= 8'h00;
      out_r <= 1'b0;
    end
    else
    begin
      if (tick)
        cnt_r <= cnt_nxt;
      // half_off selects watchdog table: one step less division
      if (half_off)
        out_r <= (ratio == 3'h0) ? tick : (tick && (cnt_nxt[ratio - 3'h1 -: 1] == 1'b0) && taps[ratio - 3'h1]);
      else
        out_r <= tick && (cnt_nxt[ratio] == 1'b0) && taps[ratio];
    end
  end
endmodule // tsp_prescaler

//--- rtl/tsp_timer.v
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ns
`include "tsp_consts.vh"
module tsp_timer (
  // clock and reset
  input wire clk,
  input wire rstn,
  // register port
  input wire [7:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  output reg [7:0] rdata,
  // core status
  input wire sleep,
  input wire watchdog_clear_instr,
  // external count pin
  input wire ext_count_input,
  // outputs
  output wire irq,
  output wire watchdog_tick,
  output wire [1:0] phase
);
  reg [7:0] timer_count_r;
  reg [7:0] option_r;
  reg [7:0] intctl_r;
  reg [1:0] phase_r;
  reg [1:0] inhibit_r;
  reg s2_r;
  reg s4_r;
  reg sync_prev_r;
  wire [7:0] timer_count_nxt;
  wire phase_two;
  wire phase_four;
  wire instr_tick;
  wire assign_wdt;
  wire src_ext;
  wire edge_fall;
  wire ext_edge;
  wire timer_src;
  wire psc_clear;
  wire psc_in;
  wire psc_out;
  wire inc;
  wire overflow;
  wire wr_count;
  wire wr_option;
  wire wr_intctl;

  assign assign_wdt = option_r[`TSP_BIT_ASSIGN];
  assign src_ext = option_r[`TSP_BIT_SRC];
  assign edge_fall = option_r[`TSP_BIT_EDGE];
  assign wr_count = wr && (addr == `TSP_ADDR_COUNT);
  assign wr_option = wr && (addr == `TSP_ADDR_OPTION);
  assign wr_intctl = wr && (addr == `TSP_ADDR_INTCTL);

  // four core phases make one instruction cycle; held during sleep
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      phase_r <= 2'h0;
    else if (!sleep)
      phase_r <= phase_r + 2'h1;
  end
  assign phase = phase_r;
  assign phase_two = (phase_r == 2'h1);
  assign phase_four = (phase_r == 2'h3);
  assign instr_tick = phase_four && !sleep;

  // pin edge, taken with the chosen polarity before the prescaler
  reg pin_prev_r;
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      pin_prev_r <= 1'b0;
    else
      pin_prev_r <= ext_count_input;
  end
  assign ext_edge = edge_fall ? (pin_prev_r && !ext_count_input) : (!pin_prev_r && ext_count_input);

  // source choice: instruction cycles or external edges
  assign timer_src = src_ext ? ext_edge : instr_tick;

  // prescaler feeds from timer source or watchdog tick; one owner only
  assign psc_in = assign_wdt ? instr_tick : (timer_src && !sleep);
  assign psc_clear = (wr_count && !assign_wdt) ||
    (watchdog_clear_instr && assign_wdt);

  tsp_prescaler u_psc (
    .clk(clk),
    .rstn(rstn),
    .clear(psc_clear),
    .tick(psc_in),
    .ratio(option_r[2:0]),
    .half_off(assign_wdt),
    .out_r(psc_out)
  );

  // watchdog gets the prescaler output only when it owns it
  assign watchdog_tick = assign_wdt ? psc_out : instr_tick;

  // prescaler output, or the pin edge when the watchdog owns the prescaler, held as a level, sampled on phase two then four
  reg psc_level_r;
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      psc_level_r <= 1'b0;
    else if (psc_clear)
      psc_level_r <= 1'b0;
    else if (src_ext && (assign_wdt ? ext_edge : psc_out))
      psc_level_r <= ~psc_level_r;
  end

  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s2_r <= 1'b0;
      s4_r <= 1'b0;
      sync_prev_r <= 1'b0;
    end
    else
    begin
      if (phase_two)
        s2_r <= psc_level_r;
      if (phase_four)
      begin
        s4_r <= s2_r;
        sync_prev_r <= s4_r;
      end
    end
  end

  // increment: synchronised external toggle, or internal path
  assign inc = !sleep && (inhibit_r == 2'h0) &&
    (src_ext ? (phase_four && (s4_r != sync_prev_r)) : (assign_wdt ? instr_tick : psc_out));
  assign timer_count_nxt = timer_count_r + 8'h01;
  assign overflow = inc && (timer_count_r == 8'hFF);

  // counter; write loads and starts the two-cycle inhibit
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      timer_count_r <= `TSP_COUNT_RESET;
      inhibit_r <= 2'h0;
    end
    else if (wr_count)
    begin
      timer_count_r <= wdata;
      inhibit_r <= `TSP_INHIBIT_CYCLES;
    end
    else
    begin
      if (inc)
        timer_count_r <= timer_count_nxt;
      if (instr_tick && (inhibit_r != 2'h0))
        inhibit_r <= inhibit_r - 2'h1;
    end
  end

  // option register; a counter write never touches it
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      option_r <= `TSP_OPTION_RESET;
    else if (wr_option)
      option_r <= wdata;
  end

  // interrupt control: flag set on every wrap, set beats clear
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      intctl_r <= `TSP_INTCTL_RESET;
    else
    begin
      if (wr_intctl)
        intctl_r <= wdata; // flag cleared only by software
      if (overflow)
        intctl_r[`TSP_BIT_OVF_FLAG] <= 1'b1;
    end
  end

  // level request gated by the enable bit
  assign irq = intctl_r[`TSP_BIT_OVF_FLAG] && intctl_r[`TSP_BIT_IRQ_EN];

  // read data one cycle after the strobe; unmapped reads zero
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      rdata <= 8'h00;
    else if (rd)
    begin
      case (addr)
        `TSP_ADDR_COUNT: rdata <= timer_count_r;
        `TSP_ADDR_INTCTL: rdata <= intctl_r;
        `TSP_ADDR_OPTION: rdata <= option_r;
        default: rdata <= 8'h00;
      endcase
    end
    else
      rdata <= 8'h00;
  end
endmodule // tsp_timer

//--- dv/tsp_timer_assertions.sv
`timescale 1ns/1ns
module tsp_timer_chk (
  // clock and reset
  input wire clk,
  input wire rstn,
  // register port
  input wire [7:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  input wire [7:0] rdata,
  // core status and outputs
  input wire sleep,
  input wire irq,
  input wire [1:0] phase
);
  // one clock domain, so one default clock and reset
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  a_phase_step: assert property (!sleep |=> phase == $past(phase) + 2'h1) else $error("phase skipped");
  a_phase_hold: assert property (sleep |=> $stable(phase)) else $error("phase ran in sleep");
  a_sleep_irq: assert property (sleep && !wr |=> !$rose(irq)) else $error("irq rose in sleep");
  a_irq_mask: assert property (wr && addr == 8'h0B && !wdata[5] |=> !irq) else $error("irq not masked");
  a_irq_hold: assert property (irq && !wr |=> irq) else $error("flag cleared by itself");
  a_count_inhibit: assert property ($past(wr && addr == 8'h01, 2) && !$past(wr) && rd && addr == 8'h01
    |=> rdata == $past(wdata, 3)) else $error("count moved after write");
  a_option_store: assert property ($past(wr && addr == 8'h81, 2) && !$past(wr) && rd && addr == 8'h81
    |=> rdata == $past(wdata, 3)) else $error("option lost");
  a_unmapped_zero: assert property (rd && addr == 8'h55 |=> rdata == 8'h00) else $error("hidden state read");
endmodule // tsp_timer_chk
bind tsp_timer tsp_timer_chk i_chk (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .sleep(sleep), .irq(irq), .phase(phase));

//--- dv/tsp_ext_src.sv
`timescale 1ns/1ns
module tsp_ext_src #(parameter int HALF = 10) (
  // clock and reset
  input wire clk,
  input wire rstn,
  // control and pin
  input wire run,
  output logic pin
);
  logic [7:0] cnt;
  // pin toggles every HALF clocks while run; long levels keep sampling safe
  always @(posedge clk or negedge rstn)
    if (!rstn)
    begin
      pin <= 1'b0;
      cnt <= 8'h00;
    end
    else if (!run)
      cnt <= 8'h00;
    else if (cnt == HALF - 1)
    begin
      cnt <= 8'h00;
      pin <= !pin;
    end
    else
      cnt <= cnt + 8'h01;
endmodule // tsp_ext_src

//--- dv/tb_timer_with_shared_prescaler.sv
`timescale 1ns/1ns
module tb_timer_with_shared_prescaler;
  logic clk = 0, rstn = 0, wr = 0, rd = 0, sleep = 0, wclr = 0, run = 0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, v;
  logic irq, wtick, pin;
  logic [1:0] phase;
  int bad_count = 0, n_tests = 0, ticks = 0, t0;
  initial forever #5 clk = ~clk;
  tsp_timer i_dut (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .sleep(sleep), .watchdog_clear_instr(wclr), .ext_count_input(pin), .irq(irq), .watchdog_tick(wtick), .phase(phase));
  tsp_ext_src #(.HALF(10)) i_src (.clk(clk), .rstn(rstn), .run(run), .pin(pin));
  always @(posedge clk) if (wtick === 1'b1) ticks <= ticks + 1;
  task check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task cyc(input int n); repeat (n) @(posedge clk); endtask
  // extra edge at the end so two writes never touch wr in one step
  task wreg(input logic [7:0] a, input logic [7:0] d);
    wr <= 1; addr <= a; wdata <= d; @(posedge clk); wr <= 0; @(posedge clk);
  endtask
  task rreg(input logic [7:0] a);
    rd <= 1; addr <= a; @(posedge clk); rd <= 0; #1 v = rdata; @(posedge clk);
  endtask
  task t_reset;
    rreg(8'h81); check(v, 8'hFF);
    rreg(8'h0B); check(v, 8'h00);
    rreg(8'h55); check(v, 8'h00);
    wreg(8'h01, 8'hA5);
    rreg(8'h01);
    check(v, 8'hA5);
    wreg(8'h81, 8'h08);
    rreg(8'h81);
    check(v, 8'h08);
  endtask
  // safe move to the watchdog at 1:1: temporary ratio, clear, select, clear, final ratio
  task t_move;
    wreg(8'h81, 8'h01);
    wreg(8'h01, 8'h00);
    wreg(8'h81, 8'h09);
    wclr <= 1;
    @(posedge clk);
    wclr <= 0;
    wreg(8'h81, 8'h08);
    t0 = ticks;
    cyc(40);
    check({7'h00, ticks - t0 >= 9 && ticks - t0 <= 11}, 8'h01);
  endtask
  task t_rate(input logic [7:0] opt, input int n, input int lo, input int hi);
    wreg(8'h81, opt); wreg(8'h01, 8'h00); cyc(n); rreg(8'h01);
    check({7'h00, v >= lo && v <= hi}, 8'h01);
  endtask
  task t_psclr;
    wreg(8'h81, 8'h01);
    repeat (6) begin wreg(8'h01, 8'h00); cyc(10); end
    rreg(8'h01); check(v, 8'h00);
    rreg(8'h81); check(v, 8'h01);
  endtask
  task t_irq;
    wreg(8'h81, 8'h08); wreg(8'h0B, 8'h00); wreg(8'h01, 8'hFD); cyc(40);
    check({7'h00, irq}, 8'h00);
    rreg(8'h0B); check(v, 8'h04);
    wreg(8'h0B, 8'h24); check({7'h00, irq}, 8'h01);
    wreg(8'h0B, 8'h04); check({7'h00, irq}, 8'h00);
    wreg(8'h0B, 8'h00); rreg(8'h0B); check(v, 8'h00);
  endtask
  task t_sleep;
    wreg(8'h0B, 8'h20); wreg(8'h01, 8'hFF); sleep <= 1; cyc(100);
    check({7'h00, irq}, 8'h00);
    rreg(8'h01); check(v, 8'hFF);
    sleep <= 0; cyc(30); check({7'h00, irq}, 8'h01);
    wreg(8'h0B, 8'h00);
  endtask
  // pin starts low: five toggles give three rises, then three give two falls
  task t_ext(input logic [7:0] opt, input int k, input logic [7:0] exp);
    wreg(8'h81, opt); wreg(8'h01, 8'h00); cyc(10);
    run <= 1; cyc(k * 10); run <= 0; cyc(20);
    rreg(8'h01); check(v, exp);
  endtask
  task t_wdclr;
    wreg(8'h81, 8'h09); t0 = ticks; cyc(40);
    check({7'h00, ticks - t0 >= 4 && ticks - t0 <= 6}, 8'h01);
    // one clear first, so a pulse already on its way is not counted
    wclr <= 1;
    @(posedge clk);
    wclr <= 0;
    cyc(2);
    t0 = ticks;
    repeat (10) begin wclr <= 1; @(posedge clk); wclr <= 0; cyc(3); end
    check(ticks - t0, 8'h00);
  endtask
  task finish_test;
    if (bad_count == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    cyc(6); rstn <= 1; cyc(1);
    t_reset; t_irq;
    t_rate(8'h08, 100, 21, 25);
    t_rate(8'h00, 100, 10, 13);
    t_rate(8'h07, 200, 0, 0);
    t_psclr; t_sleep;
    t_ext(8'h28, 5, 8'h03);
    t_ext(8'h38, 3, 8'h02);
    t_wdclr;
    t_move;
    finish_test;
  end
  // run needs about 1000 clocks; cut off far beyond that
  initial
  begin
    cyc(20000); bad_count++; finish_test;
  end
endmodule // tb_timer_with_shared_prescaler
